// >>> common/dtd_consts.svh
`ifndef DTD_CONSTS_SVH
`define DTD_CONSTS_SVH
// ---------------------------------------------------------------
// opcode field positions and patterns
// ---------------------------------------------------------------
`define DTD_OP_HI       15
`define DTD_OP_LO       12
`define DTD_N_HI        11
`define DTD_N_LO        8
`define DTD_M_HI        7
`define DTD_M_LO        4
`define DTD_SUB_HI      3
`define DTD_SUB_LO      0
`define DTD_OPC_MOVI    4'he
`define DTD_OPC_PCW     4'h9
`define DTD_OPC_PCL     4'hd
`define DTD_OPC_ST      4'h2
`define DTD_OPC_LD      4'h6
`define DTD_OPC_DSTL    4'h1
`define DTD_OPC_DLDL    4'h5
`define DTD_OPC_DR0     4'h8
`define DTD_OPC_IDX     4'h0
`define DTD_R0SEL_STB   4'h0
`define DTD_R0SEL_STW   4'h1
`define DTD_R0SEL_LDB   4'h4
`define DTD_R0SEL_LDW   4'h5
`define DTD_SUB_IDXSTB  4'h4
`define DTD_SUB_MOV     4'h3
`define DTD_REG_ZERO    4'h0
`define DTD_SZ_B        32'h0000_0001
`define DTD_SZ_W        32'h0000_0002
`define DTD_SZ_L        32'h0000_0004
`define DTD_PC_RESET    32'h0000_0000
`endif

// >>> common/dtd_pkg.sv
package dtd_pkg;
  typedef enum logic [1:0] {dtd_byte, dtd_word, dtd_long} dtd_size_e;
  typedef enum logic [1:0] {dtd_none, dtd_load, dtd_store} dtd_acc_e;
  typedef struct packed {
    logic        valid;
    dtd_acc_e    acc;
    dtd_size_e   size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0]  dest;      // load target register
    logic        wb_en;     // immediate / move result write
    logic [31:0] wb_data;
    logic        upd_en;    // pointer update write
    logic [3:0]  upd_reg;
    logic [31:0] upd_data;
  } dtd_uop_s;
endpackage

// >>> common/dtd_gpr_if.sv
`timescale 1ns/100ps
interface dtd_gpr_if;
  import dtd_pkg::*;
  logic [3:0]  ra_sel;
  logic [3:0]  rb_sel;
  logic [31:0] ra_val;
  logic [31:0] rb_val;
  logic [31:0] r0_val;
  logic        we_a;
  logic [3:0]  wa_sel;
  logic [31:0] wa_val;
  logic        we_b;
  logic [3:0]  wb_sel;
  logic [31:0] wb_val;
  modport core (output ra_sel, rb_sel, we_a, wa_sel, wa_val, we_b, wb_sel, wb_val,
                input ra_val, rb_val, r0_val);
  modport file (input ra_sel, rb_sel, we_a, wa_sel, wa_val, we_b, wb_sel, wb_val,
                output ra_val, rb_val, r0_val);
endinterface

// >>> hdl/dtd_gpr_file.sv
`timescale 1ns/100ps
`include "dtd_consts.svh"
module dtd_gpr_file
  import dtd_pkg::*;
#(
  parameter int NREG = 16
) (
  input wire logic mclk,
  input wire logic reset_n,
  dtd_gpr_if.file  gpr
);
  logic [31:0] regs [NREG];
  logic [31:0] next_regs [NREG];

  // ---------------------------------------------------------------
  // sixteen registers, binary select
  // ---------------------------------------------------------------
  // port b (load data) is written after port a so the load wins a clash
  always_comb begin
    for (int i = 0; i < NREG; i++) begin
      next_regs[i] = regs[i];
      if (gpr.we_a && gpr.wa_sel == 4'(i)) next_regs[i] = gpr.wa_val;
      if (gpr.we_b && gpr.wb_sel == 4'(i)) next_regs[i] = gpr.wb_val;
    end
  end

  // reset test sits outermost so the flops map onto a plain async clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NREG; i++) regs[i] <= 32'h0;
    end else begin
      regs <= next_regs;
    end
  end

  assign gpr.ra_val = regs[gpr.ra_sel];
  assign gpr.rb_val = regs[gpr.rb_sel];
  assign gpr.r0_val = regs[`DTD_REG_ZERO];
endmodule // dtd_gpr_file

// >>> hdl/dtd_decode.sv
`timescale 1ns/100ps
`include "dtd_consts.svh"
module dtd_decode
  import dtd_pkg::*;
(
  input  wire logic [15:0] insn,
  input  wire logic        insn_valid,
  input  wire logic [31:0] pc,
  dtd_gpr_if.core          gpr,
  output dtd_uop_s         uop
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] dtd_sext8(input logic [7:0] v);
    return {{24{v[7]}}, v};
  endfunction

  function automatic logic [31:0] dtd_scale(input logic [7:0] d, input dtd_size_e s);
    unique case (s)
      dtd_byte: return {24'h0, d};
      dtd_word: return {23'h0, d, 1'b0};
      dtd_long: return {22'h0, d, 2'b00};
      default:  return {24'h0, d};
    endcase
  endfunction

  function automatic logic [31:0] dtd_step(input dtd_size_e s);
    unique case (s)
      dtd_byte: return `DTD_SZ_B;
      dtd_word: return `DTD_SZ_W;
      default:  return `DTD_SZ_L;
    endcase
  endfunction

  logic [3:0]  opc, fn, fm, sub;
  logic [7:0]  imm8;
  logic [7:0]  d4;
  dtd_size_e   sz_low;

  // msb-first field extraction
  always_comb begin
    opc    = insn[`DTD_OP_HI:`DTD_OP_LO];
    fn     = insn[`DTD_N_HI:`DTD_N_LO];
    fm     = insn[`DTD_M_HI:`DTD_M_LO];
    sub    = insn[`DTD_SUB_HI:`DTD_SUB_LO];
    imm8   = insn[7:0];
    d4     = {4'h0, insn[3:0]};
    sz_low = dtd_size_e'(sub[1:0]);
  end

  // ---------------------------------------------------------------
  // decode into one micro-op
  // ---------------------------------------------------------------
  always_comb begin
    uop = '0;
    gpr.ra_sel = fm;
    gpr.rb_sel = fn;
    unique case (opc)
      `DTD_OPC_MOVI: begin
        uop.wb_en = 1'b1;
        uop.dest = fn;
        uop.wb_data = dtd_sext8(imm8);
      end
      `DTD_OPC_PCW, `DTD_OPC_PCL: begin
        uop.acc  = dtd_load;
        uop.size = (opc == `DTD_OPC_PCL) ? dtd_long : dtd_word;
        uop.dest = fn;
        uop.addr = pc + dtd_scale(imm8, uop.size);
      end
      `DTD_OPC_ST: if (sub[3] == 1'b0 && sz_low != 2'h3) begin
        uop.acc   = dtd_store;
        uop.size  = sz_low;
        uop.wdata = gpr.ra_val;
        uop.addr  = gpr.rb_val;
        if (sub[2]) begin
          // pre-decrement: store to the new pointer, write pointer back
          uop.addr     = gpr.rb_val - dtd_step(sz_low);
          uop.upd_en   = 1'b1;
          uop.upd_reg  = fn;
          uop.upd_data = uop.addr;
        end
      end
      `DTD_OPC_LD: if (sub == `DTD_SUB_MOV) begin
        uop.wb_en = 1'b1;
        uop.dest = fn;
        uop.wb_data = gpr.ra_val;
      end else if (sub[3] == 1'b0 && sz_low != 2'h3) begin
        uop.acc  = dtd_load;
        uop.size = sz_low;
        uop.dest = fn;
        uop.addr = gpr.ra_val;
        if (sub[2]) begin
          uop.upd_en   = 1'b1;
          uop.upd_reg  = fm;
          uop.upd_data = gpr.ra_val + dtd_step(sz_low);
        end
      end
      `DTD_OPC_DSTL: begin
        uop.acc   = dtd_store;
        uop.size  = dtd_long;
        uop.wdata = gpr.ra_val;
        uop.addr  = gpr.rb_val + dtd_scale(d4, dtd_long);
      end
      `DTD_OPC_DLDL: begin
        uop.acc  = dtd_load;
        uop.size = dtd_long;
        uop.dest = fn;
        uop.addr = gpr.ra_val + dtd_scale(d4, dtd_long);
      end
      `DTD_OPC_DR0: begin
        gpr.rb_sel = fm;  // base register sits in bits 7:4 here
        unique case (fn)
          `DTD_R0SEL_STB, `DTD_R0SEL_STW: begin
            uop.acc   = dtd_store;
            uop.size  = (fn == `DTD_R0SEL_STW) ? dtd_word : dtd_byte;
            uop.wdata = gpr.r0_val;
            uop.addr  = gpr.rb_val + dtd_scale(d4, uop.size);
          end
          `DTD_R0SEL_LDB, `DTD_R0SEL_LDW: begin
            uop.acc  = dtd_load;
            uop.size = (fn == `DTD_R0SEL_LDW) ? dtd_word : dtd_byte;
            uop.dest = `DTD_REG_ZERO;
            uop.addr = gpr.ra_val + dtd_scale(d4, uop.size);
          end
          default: ;
        endcase
      end
      `DTD_OPC_IDX: if (sub == `DTD_SUB_IDXSTB) begin
        uop.acc   = dtd_store;
        uop.size  = dtd_byte;
        uop.wdata = gpr.ra_val;
        uop.addr  = gpr.rb_val + gpr.r0_val;
      end
      default: ;
    endcase
    uop.valid = insn_valid && (uop.acc != dtd_none || uop.wb_en);
  end
endmodule // dtd_decode

// >>> hdl/dtd_core.sv
`timescale 1ns/100ps
`include "dtd_consts.svh"
// Overview of operation
// - opcode bits read msb first
// - immediate move sign-extends eight bits
// - pc-relative long load, offset times four
// - indirect byte/word loads sign-extend
// - byte pre-decrement store subtracts one
// - word pre-decrement store subtracts two
// - long pre-decrement store subtracts four
// - byte post-increment load adds one
// - long post-increment load adds four
// - register zero byte store, unscaled offset
// - register zero word store, offset times two
// - long displacement store, offset times four
// - byte displacement load into register zero
// - word displacement load into register zero
// - long displacement load, offset times four
// - indexed byte store adds register zero
// - displacement scaled by operand size
// - at least one state per instruction
// - fetch/data slot conflict stretches execution
// - load-use hazard inserts a stall
// - condition flag stays unchanged
module dtd_core
  import dtd_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [15:0] insn,
  input  wire logic        insn_valid,
  input  wire logic [31:0] insn_pc,
  input  wire logic        fetch_busy,
  output logic             insn_ready,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  output logic [1:0]       mem_size,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  input  wire logic        status_t_in,
  output logic             status_t,
  output logic             retire
);
  // ---------------------------------------------------------------
  // register file and decoder
  // ---------------------------------------------------------------
  dtd_gpr_if gpr ();
  dtd_uop_s  uop;

  dtd_gpr_file #(.NREG(16)) u_gpr (
    .mclk    (mclk),
    .reset_n (reset_n),
    .gpr     (gpr)
  );

  dtd_decode u_dec (
    .insn       (insn),
    .insn_valid (insn_valid),
    .pc         (insn_pc),
    .gpr        (gpr),
    .uop        (uop)
  );

  // ---------------------------------------------------------------
  // execution sequencer
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {dtd_idle, dtd_access, dtd_load_wb} dtd_state_e;

  dtd_state_e  state, next_state;
  logic        next_insn_ready, next_mem_req, next_mem_we, next_retire;
  logic [31:0] next_mem_addr, next_mem_wdata;
  logic [1:0]  next_mem_size;
  logic [3:0]  ld_dest, next_ld_dest;
  dtd_size_e   ld_size, next_ld_size;
  logic        ld_pend, next_ld_pend;
  logic        hazard;
  logic [31:0] ld_ext;

  // sign extension of load data by size
  always_comb begin
    unique case (ld_size)
      dtd_byte: ld_ext = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
      dtd_word: ld_ext = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
      default:  ld_ext = mem_rdata;
    endcase
  end

  // an instruction that names the register a load is still filling waits
  always_comb begin
    hazard = ld_pend && (ld_dest == gpr.ra_sel || ld_dest == gpr.rb_sel ||
                         ld_dest == `DTD_REG_ZERO);
  end

  always_comb begin
    next_state      = state;
    next_insn_ready = 1'b0;
    next_mem_req    = mem_req;
    next_mem_we     = mem_we;
    next_mem_addr   = mem_addr;
    next_mem_wdata  = mem_wdata;
    next_mem_size   = mem_size;
    next_retire     = 1'b0;
    next_ld_dest    = ld_dest;
    next_ld_size    = ld_size;
    next_ld_pend    = ld_pend;
    gpr.we_a   = 1'b0;
    gpr.wa_sel = uop.dest;
    gpr.wa_val = uop.wb_data;
    gpr.we_b   = 1'b0;
    gpr.wb_sel = ld_dest;
    gpr.wb_val = ld_ext;
    unique case (state)
      dtd_idle: begin
        // a data access waits while fetch owns the shared slot
        if (uop.valid && !insn_ready && !hazard &&
            !(fetch_busy && uop.acc != dtd_none)) begin
          next_insn_ready = 1'b1;   // consume in one state minimum
          if (uop.wb_en) begin
            gpr.we_a    = 1'b1;
            next_retire = 1'b1;
          end else begin
            next_mem_req   = 1'b1;
            next_mem_we    = (uop.acc == dtd_store);
            next_mem_addr  = uop.addr;
            next_mem_wdata = uop.wdata;
            next_mem_size  = uop.size;
            next_ld_dest   = uop.dest;
            next_ld_size   = uop.size;
            next_ld_pend   = (uop.acc == dtd_load);
            next_state     = dtd_access;
          end
          if (uop.upd_en) begin
            gpr.we_a   = 1'b1;      // pointer write-back
            gpr.wa_sel = uop.upd_reg;
            gpr.wa_val = uop.upd_data;
          end
        end
      end
      dtd_access: begin
        if (mem_ack) begin
          next_mem_req = 1'b0;
          next_retire  = 1'b1;
          if (ld_pend) begin
            gpr.we_b     = 1'b1;    // loaded value wins over post-increment
            next_ld_pend = 1'b0;
          end
          next_state = dtd_idle;
        end
      end
      default: next_state = dtd_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state      <= dtd_idle;
      insn_ready <= 1'b0;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= `DTD_PC_RESET;
      mem_wdata  <= 32'h0;
      mem_size   <= 2'h0;
      retire     <= 1'b0;
      ld_dest    <= 4'h0;
      ld_size    <= dtd_byte;
      ld_pend    <= 1'b0;
    end else begin
      state      <= next_state;
      insn_ready <= next_insn_ready;
      mem_req    <= next_mem_req;
      mem_we     <= next_mem_we;
      mem_addr   <= next_mem_addr;
      mem_wdata  <= next_mem_wdata;
      mem_size   <= next_mem_size;
      retire     <= next_retire;
      ld_dest    <= next_ld_dest;
      ld_size    <= next_ld_size;
      ld_pend    <= next_ld_pend;
    end
  end

  // ---------------------------------------------------------------
  // condition flag passes through untouched
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) status_t <= 1'b0;
    else status_t <= status_t_in;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  flag_kept_a: assert property (@(posedge mclk) disable iff (!reset_n)
    status_t == $past(status_t_in)) else $error("condition flag altered");
  slot_conflict_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state == dtd_idle && fetch_busy) |=> !$rose(mem_req)) else $error("access during fetch");
  // a load still in flight must hold off the next instruction
  hazard_stall_a: assert property (@(posedge mclk) disable iff (!reset_n)
    ld_pend |=> !insn_ready) else $error("load-use not stalled");
  min_state_a: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(mem_req) |-> !retire) else $error("retired in zero states");
  req_held_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (mem_req && !mem_ack) |=> mem_req && $stable(mem_addr)) else $error("request dropped");
  load_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state == dtd_access && mem_ack && ld_pend) |-> gpr.we_b) else $error("load lost");
  byte_ext_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (gpr.we_b && ld_size == dtd_byte) |-> gpr.wb_val[31:8] == {24{mem_rdata[7]}})
    else $error("byte sign extension wrong");
  word_ext_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (gpr.we_b && ld_size == dtd_word) |-> gpr.wb_val[31:16] == {16{mem_rdata[15]}})
    else $error("word sign extension wrong");
endmodule // dtd_core

// >>> verification/dtd_mem_model.sv
`timescale 1ns/100ps
module dtd_mem_model (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [1:0]  wait_cycles,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [1:0] cnt;
  // ----------------------------------------------------------------
  // data memory answering after wait_cycles idle edges
  // ----------------------------------------------------------------
  // read bus flips every cycle outside the ack so stale data never passes
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack   <= 1'b0;
      cnt       <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt == wait_cycles) begin
      mem_ack   <= 1'b1;
      cnt       <= 2'h0;
      mem_rdata <= {mem_addr[7:0], ~mem_addr[7:0], mem_addr[15:8], mem_addr[7:0] ^ 8'h3c};
    end else begin
      mem_ack   <= 1'b0;
      cnt       <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // dtd_mem_model

// >>> verification/tb.sv
`timescale 1ns/100ps
module tb;
  import dtd_pkg::*;
  typedef struct packed {
    logic        we;
    logic [1:0]  sz;
    logic [31:0] addr;
    logic [31:0] data;
  } dtd_exp_s;
  logic        mclk        = 1'b0;
  logic        reset_n     = 1'b0;
  logic [15:0] insn        = 16'h0;
  logic        insn_valid  = 1'b0;
  logic [31:0] insn_pc     = 32'h0;
  logic        fetch_busy  = 1'b0;
  logic        status_t_in = 1'b0;
  logic [1:0]  wait_cycles = 2'h0;
  logic        insn_ready, mem_req, mem_we, mem_ack, status_t, retire;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  logic [1:0]  mem_size;
  logic        prev_fb     = 1'b0;
  logic        prev_req    = 1'b0;
  logic        prev_t      = 1'b0;
  logic [31:0] seed        = 32'hcdfe;
  logic [31:0] rf [16];
  dtd_exp_s    expq [$];
  dtd_exp_s    e;
  int          n_fail       = 0;
  int          total_checks = 0;
  int          n_ret        = 0;
  int          n_exec       = 0;
  logic [3:0]  ops [9] = '{4'he, 4'hd, 4'h9, 4'h6, 4'h2, 4'h8, 4'h1, 4'h5, 4'h0};
  logic [15:0] corner [18] = '{16'he07f, 16'he180, 16'hd3ff, 16'h6336, 16'h1f3f, 16'h2134,
    16'h2135, 16'h2136, 16'h8010, 16'h811f, 16'h841f, 16'h851f, 16'h5f1f, 16'h0f34,
    16'h6f14, 16'h9a80, 16'h6a45, 16'h2fa2};

  dtd_core dtd_core_i (.mclk(mclk), .reset_n(reset_n), .insn(insn), .insn_valid(insn_valid),
    .insn_pc(insn_pc), .fetch_busy(fetch_busy), .insn_ready(insn_ready), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_size(mem_size),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .status_t_in(status_t_in),
    .status_t(status_t), .retire(retire));
  dtd_mem_model dtd_mem_model_i (.mclk(mclk), .reset_n(reset_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .wait_cycles(wait_cycles), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  always #12.5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] msk(logic [1:0] z);
    return (z == 2'h0) ? 32'hff : (z == 2'h1) ? 32'hffff : 32'hffff_ffff;
  endfunction
  function automatic logic [31:0] sext(logic [31:0] v, logic [1:0] z);
    return (z == 2'h0) ? {{24{v[7]}}, v[7:0]} : (z == 2'h1) ? {{16{v[15]}}, v[15:0]} : v;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // fetch contention is redrawn every cycle so slot clashes land anywhere
  task automatic tick();
    @(posedge mclk);
    fetch_busy <= (rnd() & 32'h3) == 32'h0;
  endtask

  // ----------------------------------------------------------------
  // reference model: shadow registers and expected memory accesses
  // ----------------------------------------------------------------
  task automatic ld(logic [3:0] n, logic [31:0] a, logic [1:0] z);
    expq.push_back('{1'b0, z, a, 32'h0});
    rf[n] = sext({a[7:0], ~a[7:0], a[15:8], a[7:0] ^ 8'h3c}, z);
  endtask
  task automatic st(logic [31:0] a, logic [31:0] d, logic [1:0] z);
    expq.push_back('{1'b1, z, a, d & msk(z)});
  endtask
  // post-increment updates the pointer first so a load into it wins
  task automatic step(logic [15:0] w, logic [31:0] pc);
    logic [3:0] n;
    logic [3:0] m;
    logic [3:0] s;
    n = w[11:8];
    m = w[7:4];
    s = w[3:0];
    case (w[15:12])
      4'he: rf[n] = {{24{w[7]}}, w[7:0]};
      4'h9: ld(n, pc + 32'({w[7:0], 1'b0}), 2'h1);
      4'hd: ld(n, pc + 32'({w[7:0], 2'b00}), 2'h2);
      4'h6: begin
        if (s == 4'h3) rf[n] = rf[m];
        else begin
          if (s[2]) rf[m] = rf[m] + (32'h1 << s[1:0]);
          ld(n, s[2] ? rf[m] - (32'h1 << s[1:0]) : rf[m], s[1:0]);
        end
      end
      4'h2: begin
        if (s[2]) rf[n] = rf[n] - (32'h1 << s[1:0]);
        st(rf[n], rf[m], s[1:0]);
      end
      4'h8: if (n[2]) ld(4'h0, rf[m] + (32'(s) << n[1:0]), n[1:0]);
            else st(rf[m] + (32'(s) << n[1:0]), rf[0], n[1:0]);
      4'h1: st(rf[n] + (32'(s) << 2), rf[m], 2'h2);
      4'h5: ld(n, rf[m] + (32'(s) << 2), 2'h2);
      default: st(rf[0] + rf[n], rf[m], 2'h0);
    endcase
  endtask
  function automatic logic [15:0] pick();
    logic [31:0] r;
    logic [15:0] w;
    r = rnd();
    w = r[15:0];
    w[15:12] = ops[r[19:16] % 9];
    case (w[15:12])
      4'h6: w[3:0] = (r[22:20] == 3'h7) ? 4'h3 : {1'b0, r[22:20]};
      4'h2: begin
        w[3:0] = {1'b0, r[22], r[21], r[20] & ~r[21]};
        if (w[11:8] == w[7:4]) w[7:4] = w[7:4] + 4'h1;
      end
      4'h8: w[11:8] = {1'b0, r[21], 1'b0, r[20]};
      4'h0: w[3:0] = 4'h4;
      default: ;
    endcase
    return w;
  endfunction
  // present one instruction and hold it until the core takes it
  task automatic exec(logic [15:0] w);
    logic [31:0] r;
    int k;
    r = rnd();
    step(w, {r[31:2], 2'b00});
    insn        <= w;
    insn_pc     <= {r[31:2], 2'b00};
    insn_valid  <= 1'b1;
    status_t_in <= r[0];
    wait_cycles <= r[2:1];
    k = 0;
    do begin
      tick();
      k++;
    end while (insn_ready !== 1'b1 && k < 80);
    if (k >= 80) begin
      chk(32'h0, 32'h1, "instruction never taken");
      finish_test();
    end
    n_exec++;
  endtask

  // ----------------------------------------------------------------
  // bus monitor
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    prev_fb  <= fetch_busy;
    prev_req <= mem_req;
    prev_t   <= status_t_in;
    if (reset_n && retire === 1'b1) begin
      n_ret++;
      chk(32'(status_t), 32'(prev_t), "flag");
    end
    if (reset_n && mem_req === 1'b1 && prev_req !== 1'b1)
      chk(32'(prev_fb), 32'h0, "slot clash");
    if (reset_n && mem_req === 1'b1 && mem_ack === 1'b1) begin
      if (expq.size() == 0) chk(32'h1, 32'h0, "extra access");
      else begin
        e = expq.pop_front();
        chk(32'(mem_we), 32'(e.we), "direction");
        chk(32'(mem_size), 32'(e.sz), "size");
        chk(mem_addr, e.addr, "address");
        if (e.we) chk(mem_wdata & msk(e.sz), e.data, "store data");
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int k;
    foreach (rf[i]) rf[i] = 32'h0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    tick();
    foreach (corner[i]) exec(corner[i]);
    $display("test corner done");
    // an arithmetic code lies outside this decoder and must never be taken
    insn <= 16'h3000;
    k = 0;
    repeat (10) begin
      tick();
      if (insn_ready === 1'b1) k++;
    end
    chk(32'(k), 32'h0, "foreign code taken");
    $display("test refuse done");
    repeat (400) begin
      exec(pick());
      if ((rnd() & 32'h3) == 32'h0) begin
        insn_valid <= 1'b0;
        tick();
      end
    end
    insn_valid <= 1'b0;
    k = 0;
    while ((expq.size() != 0 || mem_req !== 1'b0) && k < 200) begin
      tick();
      k++;
    end
    if (k >= 200) chk(32'h0, 32'h1, "drain timed out");
    // let the last retire pulse reach the monitor before counting
    repeat (2) tick();
    chk(32'(expq.size()), 32'h0, "accesses left over");
    chk(32'(n_ret), 32'(n_exec), "retire count");
    $display("test random done");
    finish_test();
  end
endmodule // tb
